// *** logic/temp_offset_regs.sv ***
// offset, measurement configuration and lock registers of a thermal monitor
// assumes an ahb-lite master on hclk, adc readings and limits on hclk, and
// fan presence pins that are asynchronous to hclk
// What this block does
// - local offset, signed, half-degree steps, is added to every local reading
// - remote two offset, signed, half-degree steps, added to that reading
// - with lock set, writes to both offsets and measurement_config are ignored
// - detect enable at bit 0 makes bits 3:1 show four-wire fan presence
// - bits 1 to 3 are read-only four-wire detect flags for fans one to three
// - bit 4 turns off measurement averaging for faster conversions
// - bit 5 bypasses the core voltage input attenuator
// - bit 6 converts one input continuously, chosen by external code
// - codes 1,2,5,6,7 select core, 3.3 V, remote one, local, remote two
// - bit 7 shuts down, all fan drives go to fan-off level per invert
// - during shutdown current duty cycle registers read zero
`timescale 1ns/10ps
module temp_offset_regs
  import temp_offset_pkg::*;
#(
  parameter int NUM_FANS = 3
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [temp_offset_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // adc readings and limits
  input wire temp_offset_pkg::reading_t local_raw,
  input wire temp_offset_pkg::reading_t remote_two_raw,
  input wire logic [temp_offset_pkg::TEMP_W-1:0] local_limit,
  input wire logic [temp_offset_pkg::TEMP_W-1:0] remote_two_limit,
  output logic [temp_offset_pkg::TEMP_W-1:0] local_result,
  output logic [temp_offset_pkg::TEMP_W-1:0] remote_two_result,
  output logic local_over_limit,
  output logic remote_two_over_limit,
  // converter control
  input wire logic [2:0] channel_select_code,
  output temp_offset_pkg::meas_mode_t meas_mode,
  output temp_offset_pkg::single_channel_convert_channel_t single_channel_convert_channel,
  output logic select_code_reserved,
  // fans
  input wire logic [NUM_FANS-1:0] fan_speed_sense_four_wire,
  input wire logic [NUM_FANS-1:0] fan_drive_raw,
  input wire logic [8*NUM_FANS-1:0] duty_now,
  input wire logic drive_polarity_invert,
  output logic [NUM_FANS-1:0] fan_drive,
  // alert mask and lock state
  output logic [7:0] alert_mask_first,
  output logic locked
);
  import temp_offset_pkg::*;

  addr_phase_t ap_q;
  logic [7:0] local_offset_q, remote_two_offset_q, cfg_q, mask_q;
  logic lock_q;
  logic [NUM_FANS-1:0] det_meta_q, det_sync_q;
  logic [TEMP_W-1:0] local_res_q, remote_two_res_q;
  logic local_over_q, remote_two_over_q;
  logic [31:0] rdata_q;
  logic [NUM_FANS-1:0] drive_q;
  single_channel_convert_channel_t chan_q;
  logic reserved_q;

  // bus decode
  wire logic take = hsel & hready & htrans[1];
  wire logic [IDX_W-1:0] idx_in = haddr[ADDR_W-1:2];
  wire logic wr = ap_q.valid & ap_q.write;
  wire logic wr_open = wr & ~lock_q;
  wire logic wr_local = wr_open & (ap_q.idx == IDX_LOCAL_OFFSET);
  wire logic wr_remote = wr_open & (ap_q.idx == IDX_REMOTE_TWO_OFFSET);
  wire logic wr_cfg = wr_open & (ap_q.idx == IDX_MEAS_CONFIG);
  wire logic wr_mask = wr & (ap_q.idx == IDX_ALERT_MASK_FIRST);
  wire logic wr_lock = wr & (ap_q.idx == IDX_LOCK_CONFIG);
  wire logic shutdown = cfg_q[BIT_SHUTDOWN];

  // detect flags only show while detection is enabled
  wire logic [2:0] det_view = cfg_q[BIT_DETECT_EN] ?
    det_sync_q[2:0] : 3'h0;
  wire logic [7:0] cfg_view = {cfg_q[7:4], det_view, cfg_q[0]};

  // current duty cycles, forced to idle in shutdown
  logic [8*NUM_FANS-1:0] duty_view;
  genvar g;
  generate
    for (g = 0; g < NUM_FANS; g++) begin : g_fan
      assign duty_view[8*g +: 8] = shutdown ?
        DUTY_IDLE : duty_now[8*g +: 8];
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          drive_q[g] <= 1'b0;
        end else begin
          drive_q[g] <= shutdown ?
            drive_polarity_invert : fan_drive_raw[g];
        end
      end
    end
  endgenerate

  // read mux; unmapped addresses read zero
  logic [7:0] rd_byte;
  logic [IDX_W-1:0] duty_rel;
  always_comb begin
    duty_rel = idx_in - IDX_DUTY_BASE;
    if (idx_in == IDX_LOCAL_OFFSET) begin
      rd_byte = local_offset_q;
    end else if (idx_in == IDX_REMOTE_TWO_OFFSET) begin
      rd_byte = remote_two_offset_q;
    end else if (idx_in == IDX_MEAS_CONFIG) begin
      rd_byte = cfg_view;
    end else if (idx_in == IDX_ALERT_MASK_FIRST) begin
      rd_byte = mask_q;
    end else if (idx_in == IDX_LOCK_CONFIG) begin
      rd_byte = 8'(lock_q) << BIT_LOCK;
    end else if (idx_in == IDX_LOCAL_RESULT) begin
      rd_byte = local_res_q[TEMP_W-1 -: 8];
    end else if (idx_in == IDX_REMOTE_TWO_RESULT) begin
      rd_byte = remote_two_res_q[TEMP_W-1 -: 8];
    end else if (idx_in >= IDX_DUTY_BASE &&
                 duty_rel < IDX_W'(NUM_FANS)) begin
      rd_byte = duty_view[8*duty_rel +: 8];
    end else begin
      rd_byte = 8'h00;
    end
  end

  // offset in half degrees is twice the reading's quarter-degree step;
  // the sum is clamped to the reading's range instead of wrapping
  function automatic logic [TEMP_W-1:0] correct(
    input logic [TEMP_W-1:0] raw,
    input logic [7:0] off
  );
    logic signed [TEMP_W+1:0] sum;
    sum = $signed({2'b00, raw}) + $signed({{(TEMP_W-8){off[7]}}, off, 1'b0});
    if (sum < 0) begin
      correct = '0;
    end else if (sum > $signed({2'b00, TEMP_MAX})) begin
      correct = TEMP_MAX;
    end else begin
      correct = sum[TEMP_W-1:0];
    end
  endfunction

  wire logic [TEMP_W-1:0] local_fix =
    correct(local_raw.value, local_offset_q);
  wire logic [TEMP_W-1:0] remote_two_fix =
    correct(remote_two_raw.value, remote_two_offset_q);

  // bus pipeline and registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q <= '0;
      rdata_q <= '0;
    end else if (hready) begin
      ap_q <= '{valid: take, write: hwrite, idx: idx_in};
      rdata_q <= (take & ~hwrite) ? {24'h0, rd_byte} : 32'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      local_offset_q <= RST_OFFSET;
      remote_two_offset_q <= RST_OFFSET;
      cfg_q <= RST_MEAS_CONFIG;
      mask_q <= RST_ALERT_MASK;
      lock_q <= 1'b0;
    end else begin
      if (wr_local) local_offset_q <= hwdata[7:0];
      if (wr_remote) remote_two_offset_q <= hwdata[7:0];
      if (wr_cfg) cfg_q <= hwdata[7:0] & CFG_WRITE_MASK;
      if (wr_mask) mask_q <= hwdata[7:0];
      // lock only clears at reset, so software cannot undo it
      if (wr_lock & hwdata[BIT_LOCK]) lock_q <= 1'b1;
    end
  end

  // presence pins come from the fan connectors, asynchronous to hclk
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      det_meta_q <= '0;
      det_sync_q <= '0;
    end else begin
      det_meta_q <= fan_speed_sense_four_wire;
      det_sync_q <= det_meta_q;
    end
  end

  // corrected readings are stored and compared, never the raw ones
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      local_res_q <= '0;
      remote_two_res_q <= '0;
      local_over_q <= 1'b0;
      remote_two_over_q <= 1'b0;
    end else begin
      if (local_raw.valid) begin
        local_res_q <= local_fix;
        local_over_q <= local_fix > local_limit;
      end
      if (remote_two_raw.valid) begin
        remote_two_res_q <= remote_two_fix;
        remote_two_over_q <= remote_two_fix > remote_two_limit;
      end
    end
  end

  // single-channel select; reserved codes keep the last legal channel
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan_q <= CH_LOCAL;
      reserved_q <= 1'b0;
    end else begin
      reserved_q <= 1'b0;
      case (channel_select_code)
        SEL_CORE_V: chan_q <= CH_CORE_V;
        SEL_SUPPLY_3V3: chan_q <= CH_SUPPLY;
        SEL_REMOTE_ONE: chan_q <= CH_REMOTE_ONE;
        SEL_LOCAL: chan_q <= CH_LOCAL;
        SEL_REMOTE_TWO: chan_q <= CH_REMOTE_TWO;
        default: reserved_q <= 1'b1;
      endcase
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign local_result = local_res_q;
  assign remote_two_result = remote_two_res_q;
  assign local_over_limit = local_over_q;
  assign remote_two_over_limit = remote_two_over_q;
  assign meas_mode.no_averaging = cfg_q[BIT_NO_AVG];
  assign meas_mode.attenuator_bypass = cfg_q[BIT_ATTENUATOR_BYPASS_BYPASS];
  assign meas_mode.single_channel_convert = cfg_q[BIT_SINGLE_SINGLE_CHANNEL_CONVERT];
  assign meas_mode.shutdown_request = shutdown;
  assign single_channel_convert_channel = chan_q;
  assign select_code_reserved = reserved_q;
  assign fan_drive = drive_q;
  assign alert_mask_first = mask_q;
  assign locked = lock_q;
endmodule

// *** inc/temp_offset_pkg.sv ***
// package for the temperature offset and measurement configuration registers
// assumes a word-wide ahb-lite bus with each register on one aligned word
package temp_offset_pkg;
  localparam int ADDR_W = 10;
  localparam int IDX_W = 8;
  localparam int TEMP_W = 10;
  // register indexes; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_LOCAL_OFFSET = 8'h71;
  localparam logic [IDX_W-1:0] IDX_REMOTE_TWO_OFFSET = 8'h72;
  localparam logic [IDX_W-1:0] IDX_MEAS_CONFIG = 8'h73;
  localparam logic [IDX_W-1:0] IDX_ALERT_MASK_FIRST = 8'h74;
  localparam logic [IDX_W-1:0] IDX_LOCK_CONFIG = 8'h40;
  localparam logic [IDX_W-1:0] IDX_DUTY_BASE = 8'h30;
  localparam logic [IDX_W-1:0] IDX_LOCAL_RESULT = 8'h80;
  localparam logic [IDX_W-1:0] IDX_REMOTE_TWO_RESULT = 8'h81;
  // reset values
  localparam logic [7:0] RST_OFFSET = 8'h00;
  localparam logic [7:0] RST_MEAS_CONFIG = 8'h00;
  localparam logic [7:0] RST_ALERT_MASK = 8'h00;
  localparam logic [7:0] DUTY_IDLE = 8'h00;
  // measurement_config fields
  localparam int BIT_DETECT_EN = 0;
  localparam int BIT_DETECT_LO = 1;
  localparam int BIT_NO_AVG = 4;
  localparam int BIT_ATTENUATOR_BYPASS_BYPASS = 5;
  localparam int BIT_SINGLE_SINGLE_CHANNEL_CONVERT = 6;
  localparam int BIT_SHUTDOWN = 7;
  localparam logic [7:0] CFG_WRITE_MASK = 8'hf1;
  // lock_config field
  localparam int BIT_LOCK = 1;
  // single-channel select codes
  localparam logic [2:0] SEL_CORE_V = 3'h1;
  localparam logic [2:0] SEL_SUPPLY_3V3 = 3'h2;
  localparam logic [2:0] SEL_REMOTE_ONE = 3'h5;
  localparam logic [2:0] SEL_LOCAL = 3'h6;
  localparam logic [2:0] SEL_REMOTE_TWO = 3'h7;
  localparam logic [TEMP_W-1:0] TEMP_MAX = 10'h3ff;

  typedef enum logic [4:0] {
    CH_CORE_V = 5'b00001,
    CH_SUPPLY = 5'b00010,
    CH_REMOTE_ONE = 5'b00100,
    CH_LOCAL = 5'b01000,
    CH_REMOTE_TWO = 5'b10000
  } single_channel_convert_channel_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [IDX_W-1:0] idx;
  } addr_phase_t;

  typedef struct packed {
    logic valid;
    logic [TEMP_W-1:0] value;
  } reading_t;

  typedef struct packed {
    logic no_averaging;
    logic attenuator_bypass;
    logic single_channel_convert;
    logic shutdown_request;
  } meas_mode_t;
endpackage

// *** tb/temp_offset_regs_chk.sv ***
// assertions on the ports of the offset and configuration register block
// assumes one hclk domain and hresetn asynchronous, active low
`timescale 1ns/10ps
module temp_offset_regs_chk
  import temp_offset_pkg::*;
#(
  parameter int NUM_FANS = 3
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [temp_offset_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // readings and control
  input wire temp_offset_pkg::reading_t local_raw,
  input wire logic [temp_offset_pkg::TEMP_W-1:0] local_limit,
  input wire logic [temp_offset_pkg::TEMP_W-1:0] local_result,
  input wire logic local_over_limit,
  input wire logic [2:0] channel_select_code,
  input wire temp_offset_pkg::meas_mode_t meas_mode,
  input wire temp_offset_pkg::single_channel_convert_channel_t single_channel_convert_channel,
  input wire logic select_code_reserved,
  // fans and lock
  input wire logic [NUM_FANS-1:0] fan_drive_raw,
  input wire logic drive_polarity_invert,
  input wire logic [NUM_FANS-1:0] fan_drive,
  input wire logic locked
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire rd_take = hsel && hready && htrans[1] && !hwrite;
  wire [2:0] c = channel_select_code;
  wire rsv = (c == 3'h0) || (c == 3'h3) || (c == 3'h4);
  wire [4:0] ch_exp = {c == 3'h7, c == 3'h6, c == 3'h5, c == 3'h2, c == 3'h1};
  sequence duty_rd;
    rd_take && haddr[9:2] >= IDX_DUTY_BASE && haddr[9:2] <= 8'h32;
  endsequence
  sequence in_off;
    meas_mode.shutdown_request;
  endsequence
  chk_bus_okay:
    assert property (hreadyout && !hresp) else $error("bus not ready okay");
  chk_idle_read:
    assert property (hready && !rd_take |=> hrdata == 32'h0)
    else $error("read data left standing");
  chk_duty_zero:
    assert property (duty_rd ##0 in_off |=> hrdata == 32'h0)
    else $error("duty read not zero in shutdown");
  chk_drive_off:
    assert property (in_off |=>
      fan_drive == {NUM_FANS{$past(drive_polarity_invert)}})
    else $error("fan drive not at off level");
  chk_drive_pass:
    assert property (!in_off |=> fan_drive == $past(fan_drive_raw))
    else $error("fan drive not passed through");
  chk_limit_after:
    assert property (local_raw.valid |=>
      local_over_limit == (local_result > $past(local_limit)))
    else $error("limit compare not on corrected value");
  chk_chan_map:
    assert property (!rsv |=> single_channel_convert_channel == $past(ch_exp))
    else $error("channel select decode wrong");
  chk_chan_hold:
    assert property (rsv |=> $stable(single_channel_convert_channel))
    else $error("channel moved on reserved code");
  chk_rsv_flag:
    assert property (1'b1 |=> select_code_reserved == $past(rsv))
    else $error("reserved code flag wrong");
  chk_lock_sticky:
    assert property (locked |=> locked) else $error("lock bit cleared");
endmodule
bind temp_offset_regs temp_offset_regs_chk #(.NUM_FANS(NUM_FANS))
  temp_offset_regs_chk_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hreadyout, .hresp, .hrdata, .local_raw, .local_limit,
  .local_result, .local_over_limit, .channel_select_code, .meas_mode,
  .single_channel_convert_channel, .select_code_reserved, .fan_drive_raw,
  .drive_polarity_invert, .fan_drive, .locked);

// *** tb/tb_temp_offset_regs.sv ***
// self-checking bench for the offset and configuration register block
// assumes the block is the only slave on the bus, so hready is its own
`timescale 1ns/10ps
module tb_temp_offset_regs;
  import temp_offset_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, pol = 0;
  logic [1:0] htrans = 0;
  logic [ADDR_W-1:0] haddr = 0;
  logic [TEMP_W-1:0] lim = 10'h0ff;
  logic [31:0] hwdata = 0;
  logic [2:0] sel = 0, fans = 3'h5, raw_drive = 3'h2;
  logic [23:0] duty = 24'h112233;
  reading_t lraw = 0, r2raw = 0;
  wire hready, lover, r2over, rsvd, locked;
  wire [31:0] hrdata;
  wire [TEMP_W-1:0] lres, r2res;
  wire [2:0] fan_drive;
  wire [7:0] amask;
  meas_mode_t mode;
  single_channel_convert_channel_t chan;
  int failures = 0, check_count = 0, cycles = 0;
  temp_offset_regs temp_offset_regs_i (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready, .hreadyout(hready), .hresp(), .hrdata,
    .local_raw(lraw), .remote_two_raw(r2raw), .local_limit(lim),
    .remote_two_limit(lim), .local_result(lres),
    .remote_two_result(r2res), .local_over_limit(lover),
    .remote_two_over_limit(r2over), .channel_select_code(sel),
    .meas_mode(mode), .single_channel_convert_channel(chan), .select_code_reserved(rsvd),
    .fan_speed_sense_four_wire(fans), .fan_drive_raw(raw_drive),
    .duty_now(duty), .drive_polarity_invert(pol), .fan_drive,
    .alert_mask_first(amask), .locked);
  always #5 hclk = ~hclk;
  // a hung handshake ends here rather than running forever
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("failures %0d of %0d checks", failures, check_count);
    if (failures == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] i,
                     input logic [7:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {i, 2'h0};
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, i, d, r);
  endtask
  task automatic rd(input logic [7:0] i, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, i, 8'h0, r);
    chk(r, e);
  endtask
  // one reading on both channels, judged once the result has landed
  task automatic pulse(input logic [9:0] v, input logic [9:0] el,
                       input logic [9:0] er);
    @(posedge hclk);
    lraw <= '{1'b1, v};
    r2raw <= '{1'b1, v};
    @(posedge hclk);
    lraw.valid <= 0;
    r2raw.valid <= 0;
    @(posedge hclk);
    chk({22'h0, lres}, {22'h0, el});
    chk({22'h0, r2res}, {22'h0, er});
    chk({30'h0, lover, r2over}, {30'h0, el > lim, er > lim});
  endtask
  task automatic t_reset();
    rd(IDX_LOCAL_OFFSET, 32'h0);
    rd(IDX_REMOTE_TWO_OFFSET, 32'h0);
    rd(IDX_MEAS_CONFIG, 32'h0);
    rd(IDX_ALERT_MASK_FIRST, 32'h0);
    rd(8'h10, 32'h0);
  endtask
  task automatic t_offset();
    wr(IDX_LOCAL_OFFSET, 8'hfe);
    wr(IDX_REMOTE_TWO_OFFSET, 8'h04);
    rd(IDX_LOCAL_OFFSET, 32'hfe);
    pulse(10'h100, 10'h0fc, 10'h108);
    wr(IDX_LOCAL_OFFSET, 8'h80);
    pulse(10'h010, 10'h000, 10'h018);
  endtask
  task automatic t_config();
    wr(IDX_MEAS_CONFIG, 8'h7f);
    rd(IDX_MEAS_CONFIG, 32'h7b);
    chk({28'h0, mode}, 32'he);
    fans <= 3'h2;
    // the presence pins pass two sync stages before the flags show them
    repeat (2) @(posedge hclk);
    rd(IDX_MEAS_CONFIG, 32'h75);
    wr(IDX_MEAS_CONFIG, 8'h80);
    pol <= 1;
    rd(IDX_MEAS_CONFIG, 32'h80);
    rd(IDX_DUTY_BASE, 32'h0);
    rd(8'h32, 32'h0);
    chk({29'h0, fan_drive}, 32'h7);
    wr(IDX_MEAS_CONFIG, 8'h00);
    rd(8'h32, 32'h11);
    chk({29'h0, fan_drive}, 32'h2);
  endtask
  task automatic t_select();
    logic [4:0] last;
    last = CH_LOCAL;
    for (int c = 0; c < 8; c++) begin
      sel <= 3'(c);
      repeat (3) @(posedge hclk);
      if (c == 1 || c == 2 || c > 4) last = 5'h1 << (c < 3 ? c - 1 : c - 3);
      chk({27'h0, chan}, {27'h0, last});
      chk({31'h0, rsvd}, {31'h0, c == 0 || c == 3 || c == 4});
    end
  endtask
  task automatic t_lock();
    wr(IDX_LOCK_CONFIG, 8'h02);
    @(posedge hclk);
    chk({31'h0, locked}, 32'h1);
    wr(IDX_LOCAL_OFFSET, 8'h11);
    wr(IDX_REMOTE_TWO_OFFSET, 8'h22);
    wr(IDX_MEAS_CONFIG, 8'h10);
    wr(IDX_ALERT_MASK_FIRST, 8'ha5);
    rd(IDX_LOCAL_OFFSET, 32'h80);
    rd(IDX_REMOTE_TWO_OFFSET, 32'h04);
    rd(IDX_MEAS_CONFIG, 32'h0);
    rd(IDX_ALERT_MASK_FIRST, 32'ha5);
    chk({24'h0, amask}, 32'ha5);
    hresetn <= 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1;
    rd(IDX_LOCAL_OFFSET, 32'h0);
    chk({31'h0, locked}, 32'h0);
  endtask
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1;
    t_reset();
    t_offset();
    t_config();
    t_select();
    t_lock();
    give_verdict();
  end
endmodule
